// >>> hdl/pxr_consts.svh
`ifndef PXR_CONSTS_SVH
`define PXR_CONSTS_SVH

`define PXR_ADDR_CMD1     3'h0
`define PXR_ADDR_CFG      3'h1
`define PXR_ADDR_RES_LO   3'h2
`define PXR_ADDR_RES_HI   3'h3
`define PXR_ADDR_TLO_LO   3'h4
`define PXR_ADDR_TLO_HI   3'h5
`define PXR_ADDR_THI_LO   3'h6
`define PXR_ADDR_THI_HI   3'h7

`define PXR_CMD1_RST      8'h00
`define PXR_CFG_RST       8'h00
`define PXR_TLO_RST       8'h00
`define PXR_THI_RST       8'hFF

`define PXR_OP_MSB        7
`define PXR_OP_LSB        5
`define PXR_FLAG_BIT      2
`define PXR_PRST_MSB      1
`define PXR_PRST_LSB      0
`define PXR_SCHEME_BIT    7
`define PXR_MOD_BIT       6
`define PXR_CUR_MSB       5
`define PXR_CUR_LSB       4
`define PXR_RES_MSB       3
`define PXR_RES_LSB       2
`define PXR_RNG_MSB       1
`define PXR_RNG_LSB       0

`define PXR_OSC_KHZ       725
`define PXR_MOD_KHZ       360
`define PXR_CLK_KHZ       50000

`endif

// >>> hdl/pxr_pkg.sv
package pxr_pkg;
  typedef enum logic [2:0] {
    PXR_OP_DOWN     = 3'h0,
    PXR_OP_IR_ONCE  = 3'h2,
    PXR_OP_PX_ONCE  = 3'h3,
    PXR_OP_IR_CONT  = 3'h6,
    PXR_OP_PX_CONT  = 3'h7
  } pxr_op_t;

  typedef enum logic [1:0] {
    PXR_IDLE,
    PXR_INTEG,
    PXR_DONE
  } pxr_phase_t;

  typedef struct packed {
    logic [7:0]  cmd1;
    logic [7:0]  cfg;
    logic [15:0] tlo;
    logic [15:0] thi;
    logic [15:0] result;
    logic [7:0]  rd_data;
    logic [15:0] rd_snap;
    logic        flag;
    logic [4:0]  persist;
    pxr_phase_t  phase;
    logic [16:0] integ_cnt;
    logic [2:0]  run_op;
    logic        ack;
  } pxr_state_t;
endpackage

// >>> hdl/pxr_divider.sv
`timescale 1ns/100ps
`include "pxr_consts.svh"
module pxr_divider #(
  parameter int unsigned CLK_KHZ = `PXR_CLK_KHZ,
  parameter int unsigned OUT_KHZ = `PXR_OSC_KHZ
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic run_i,
  output logic      tick_o
);
  localparam int unsigned DIV = (CLK_KHZ / OUT_KHZ) < 1 ? 1 : CLK_KHZ / OUT_KHZ;
  localparam int unsigned CW  = $clog2(DIV + 1);
  logic [CW-1:0] cnt;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !run_i) begin
      cnt    <= '0;
      tick_o <= 1'b0;
    end else if (cnt == CW'(DIV - 1)) begin
      cnt    <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt    <= cnt + 1'b1;
      tick_o <= 1'b0;
    end
  end
endmodule

// >>> hdl/pxr_core.sv
`timescale 1ns/100ps
`include "pxr_consts.svh"
// Overview of operation
// - scheme bit 1 yields ambient-subtracted proximity as n-bit two's complement
// - ambient-subtracted count spans -2^(n-1) up to 2^(n-1)-1
// - config bit 6: 0 drives LED steady, 1 modulates at 360 kHz
// - config bits 5:4 pick LED current 12.5, 25, 50 or 100 mA
// - config bits 3:2 pick 16/12/8/4 bits over 65536/4096/256/16 clocks
// - integration lasts exactly 2^n oscillator clocks
// - config bits 1:0 pick full-scale range k = code plus one
// - result readable as low byte at 02, high byte at 03
// - result sits in D0 upward, width set by resolution
// - result overwritten at end of every conversion; 03 returns the high byte copied when 02 was last read
// - low threshold at 04/05, resets to 00
// - high threshold at 06/07, resets to FF
// - integration clock is 725 kHz oscillator, scaled by external resistor
// - command bits 7:5 select power down, single or continuous IR/proximity
// - interrupt only after m consecutive out-of-window results, m = 1/4/8/16
// - flag and low pin hold until a first command register access completes
// - LED driver enabled only for proximity sensing
module pxr_core
  import pxr_pkg::*;
#(
  parameter int unsigned OSC_KHZ = `PXR_OSC_KHZ,
  parameter int unsigned MOD_KHZ = `PXR_MOD_KHZ
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [2:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        xfer_end_i,
  output logic [7:0]       reg_rdata_o,
  output logic             reg_ack_o,
  input  wire logic [15:0] adc_raw_i,
  input  wire logic [15:0] adc_ambient_i,
  output logic             led_drive_pin_o,
  output logic [1:0]       led_current_o,
  output logic [1:0]       full_scale_range_o,
  output logic             converting_o,
  output logic             int_n_o,
  output logic             int_n_oe_o
);
  pxr_state_t st;
  pxr_state_t next_st;
  logic       osc_tick;
  logic       mod_tick;
  logic       mod_phase;
  logic       running;
  logic       flag_event;

  function automatic logic [4:0] res_bits(input logic [1:0] code);
    unique case (code)
      2'b00:   res_bits = 5'd16;
      2'b01:   res_bits = 5'd12;
      2'b10:   res_bits = 5'd8;
      2'b11:   res_bits = 5'd4;
    endcase
  endfunction

  function automatic logic [4:0] persist_len(input logic [1:0] code);
    unique case (code)
      2'b00:   persist_len = 5'd1;
      2'b01:   persist_len = 5'd4;
      2'b10:   persist_len = 5'd8;
      2'b11:   persist_len = 5'd16;
    endcase
  endfunction

  function automatic logic op_legal(input logic [2:0] op);
    op_legal = (op == PXR_OP_DOWN) || (op == PXR_OP_IR_ONCE) || (op == PXR_OP_PX_ONCE)
            || (op == PXR_OP_IR_CONT) || (op == PXR_OP_PX_CONT);
  endfunction

  // result width mask and ambient-subtracted value
  logic [4:0]  nbits;
  logic [16:0] full_cnt;
  logic [15:0] res_mask;
  logic [16:0] diff;
  logic [16:0] half_cnt;
  logic [15:0] sample;
  logic        is_prox;
  logic        out_window;
  always_comb begin
    nbits    = res_bits(st.cfg[`PXR_RES_MSB:`PXR_RES_LSB]);
    full_cnt = 17'h00001 << nbits;
    res_mask = 16'(full_cnt - 17'h00001);
    is_prox  = st.run_op[0];
    half_cnt = full_cnt >> 1;
    diff     = {1'b0, adc_raw_i} - {1'b0, adc_ambient_i};
    // saturate so the value stays within n-bit two's complement
    if (diff[16] && (diff < 17'h00000 - half_cnt))
      diff = 17'h00000 - half_cnt;
    else if (!diff[16] && (diff > half_cnt - 17'h00001))
      diff = half_cnt - 17'h00001;
    // two's complement within n bits, sign at bit n-1
    if (is_prox && st.cfg[`PXR_SCHEME_BIT])
      sample = diff[15:0] & res_mask;
    else
      sample = adc_raw_i & res_mask;
    out_window = (sample < st.tlo) || (sample > st.thi);
  end

  assign running = (st.phase == PXR_INTEG);

  pxr_divider #(.OUT_KHZ(OSC_KHZ)) u_osc (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .run_i     (running),
    .tick_o    (osc_tick)
  );

  pxr_divider #(.OUT_KHZ(2 * MOD_KHZ)) u_mod (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .run_i     (running),
    .tick_o    (mod_tick)
  );

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !running)
      mod_phase <= 1'b0;
    else if (mod_tick)
      mod_phase <= ~mod_phase;
  end

  always_comb begin
    next_st     = st;
    next_st.ack = 1'b0;
    flag_event  = 1'b0;
    // register writes; scheme bit forced to its only legal value
    if (reg_wr_i) begin
      next_st.ack = 1'b1;
      unique case (reg_addr_i)
        `PXR_ADDR_CMD1: begin
          next_st.cmd1[`PXR_OP_MSB:`PXR_OP_LSB]   = reg_wdata_i[`PXR_OP_MSB:`PXR_OP_LSB];
          next_st.cmd1[`PXR_PRST_MSB:`PXR_PRST_LSB] = reg_wdata_i[`PXR_PRST_MSB:`PXR_PRST_LSB];
          if (reg_wdata_i[`PXR_OP_MSB:`PXR_OP_LSB] != st.cmd1[`PXR_OP_MSB:`PXR_OP_LSB])
            next_st.persist = '0;
        end
        `PXR_ADDR_CFG:    next_st.cfg = reg_wdata_i | 8'h80;
        `PXR_ADDR_TLO_LO: next_st.tlo[7:0]  = reg_wdata_i;
        `PXR_ADDR_TLO_HI: next_st.tlo[15:8] = reg_wdata_i;
        `PXR_ADDR_THI_LO: next_st.thi[7:0]  = reg_wdata_i;
        `PXR_ADDR_THI_HI: next_st.thi[15:8] = reg_wdata_i;
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      next_st.ack = 1'b1;
      unique case (reg_addr_i)
        `PXR_ADDR_CMD1:   next_st.rd_data = {st.cmd1[7:3], st.flag, st.cmd1[1:0]};
        `PXR_ADDR_CFG:    next_st.rd_data = st.cfg;
        `PXR_ADDR_RES_LO: begin
          next_st.rd_data = st.result[7:0];
          next_st.rd_snap = st.result;
        end
        `PXR_ADDR_RES_HI: next_st.rd_data = st.rd_snap[15:8];
        `PXR_ADDR_TLO_LO: next_st.rd_data = st.tlo[7:0];
        `PXR_ADDR_TLO_HI: next_st.rd_data = st.tlo[15:8];
        `PXR_ADDR_THI_LO: next_st.rd_data = st.thi[7:0];
        `PXR_ADDR_THI_HI: next_st.rd_data = st.thi[15:8];
      endcase
    end
    // conversion sequencing
    unique case (st.phase)
      PXR_IDLE: begin
        if (st.cmd1[`PXR_OP_MSB:`PXR_OP_LSB] != 3'(PXR_OP_DOWN)
            && op_legal(st.cmd1[`PXR_OP_MSB:`PXR_OP_LSB])) begin
          next_st.phase     = PXR_INTEG;
          next_st.run_op    = st.cmd1[`PXR_OP_MSB:`PXR_OP_LSB];
          next_st.integ_cnt = '0;
        end
      end
      PXR_INTEG: begin
        if (osc_tick)
          next_st.integ_cnt = st.integ_cnt + 17'h00001;
        if (osc_tick && (st.integ_cnt + 17'h00001 >= full_cnt))
          next_st.phase = PXR_DONE;
        if (st.cmd1[`PXR_OP_MSB:`PXR_OP_LSB] == 3'(PXR_OP_DOWN))
          next_st.phase = PXR_IDLE;
      end
      PXR_DONE: begin
        next_st.result = sample;
        if (out_window) begin
          if (st.persist + 5'd1 >= persist_len(st.cmd1[`PXR_PRST_MSB:`PXR_PRST_LSB])) begin
            next_st.flag = 1'b1;
            flag_event   = 1'b1;
          end
          if (st.persist != 5'd16)
            next_st.persist = st.persist + 5'd1;
        end else begin
          next_st.persist = '0;
        end
        if (st.run_op[2] && st.cmd1[`PXR_OP_MSB:`PXR_OP_LSB] == st.run_op) begin
          next_st.phase     = PXR_INTEG;
          next_st.integ_cnt = '0;
        end else begin
          next_st.phase = PXR_IDLE;
          if (st.cmd1[`PXR_OP_MSB:`PXR_OP_LSB] == st.run_op)
            next_st.cmd1[`PXR_OP_MSB:`PXR_OP_LSB] = 3'(PXR_OP_DOWN);
        end
      end
      default: next_st.phase = PXR_IDLE;
    endcase
    // first command register transfer end clears flag, unless set this cycle
    if (xfer_end_i && reg_addr_i == `PXR_ADDR_CMD1 && !flag_event)
      next_st.flag = 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st         <= '0;
      st.cmd1    <= `PXR_CMD1_RST;
      st.cfg     <= `PXR_CFG_RST;
      st.tlo     <= {`PXR_TLO_RST, `PXR_TLO_RST};
      st.thi     <= {`PXR_THI_RST, `PXR_THI_RST};
      st.phase   <= PXR_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_o        = st.rd_data;
  assign reg_ack_o          = st.ack;
  assign converting_o       = running;
  assign led_current_o      = st.cfg[`PXR_CUR_MSB:`PXR_CUR_LSB];
  assign full_scale_range_o = st.cfg[`PXR_RNG_MSB:`PXR_RNG_LSB];
  // LED only in proximity integration; steady or 50% square wave
  assign led_drive_pin_o    = running && st.run_op[0]
                              && (!st.cfg[`PXR_MOD_BIT] || mod_phase);
  assign int_n_o            = 1'b0;
  assign int_n_oe_o         = st.flag;

  a_led_only_prox: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    led_drive_pin_o |-> (st.run_op[0] && st.phase == PXR_INTEG))
    else $error("led driven outside proximity integration");

  a_led_steady_dc: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (running && st.run_op[0] && !st.cfg[`PXR_MOD_BIT]) |-> led_drive_pin_o)
    else $error("led not steady in dc mode");

  a_int_pin_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (reg_rd_i && reg_addr_i == `PXR_ADDR_CMD1)
    |=> (reg_rdata_o[`PXR_FLAG_BIT] == $past(int_n_oe_o)) && !int_n_o)
    else $error("interrupt pin and status bit disagree");

  a_flag_holds: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (st.flag && !(xfer_end_i && reg_addr_i == `PXR_ADDR_CMD1)) |=> st.flag)
    else $error("flag dropped without command access");

  a_flag_set_wins: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    flag_event |=> st.flag)
    else $error("flag set lost against a clear");

  a_result_update: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (st.phase == PXR_DONE) |=> (st.result == $past(sample)))
    else $error("result not written at conversion end");

  a_result_width: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (st.cfg[`PXR_RES_MSB:`PXR_RES_LSB] == 2'b11 && st.phase == PXR_DONE)
    |=> st.result[15:4] == 12'h000)
    else $error("4-bit result has high bits set");

  a_integ_bound: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    running |-> st.integ_cnt < full_cnt)
    else $error("integration exceeded 2^n clocks");

  a_scheme_one: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (reg_wr_i && reg_addr_i == `PXR_ADDR_CFG) |=> st.cfg[`PXR_SCHEME_BIT])
    else $error("scheme bit not held at one");

  a_persist_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(st.flag) |-> $past(st.persist) + 5'd1
      >= persist_len($past(st.cmd1[`PXR_PRST_MSB:`PXR_PRST_LSB])))
    else $error("flag raised before persistence count");

  a_snap_pair: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (reg_rd_i && reg_addr_i == `PXR_ADDR_RES_LO) |=> st.rd_snap[7:0] == st.rd_data)
    else $error("low byte read did not snapshot result");

  a_once_stops: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (st.phase == PXR_DONE && !st.run_op[2]) |=> !running)
    else $error("single conversion did not stop");

  a_down_stops: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (running && st.cmd1[`PXR_OP_MSB:`PXR_OP_LSB] == 3'(PXR_OP_DOWN)) |=> !running)
    else $error("power down did not stop integration");

  a_reserved_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (st.phase == PXR_IDLE && !op_legal(st.cmd1[`PXR_OP_MSB:`PXR_OP_LSB])) |=> !running)
    else $error("reserved operation started a conversion");

  a_tlo_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (reg_wr_i && reg_addr_i == `PXR_ADDR_TLO_HI) |=> st.tlo[15:8] == $past(reg_wdata_i))
    else $error("low threshold write lost");

  a_thi_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (reg_wr_i && reg_addr_i == `PXR_ADDR_THI_HI) |=> st.thi[15:8] == $past(reg_wdata_i))
    else $error("high threshold write lost");

  a_ack_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (reg_wr_i || reg_rd_i) |=> reg_ack_o)
    else $error("register access not acknowledged");
endmodule

// >>> verif/pxr_host.sv
`timescale 1ns/100ps
module pxr_host (
  input  wire logic       clk_i,
  input  wire logic       ack_i,
  input  wire logic [7:0] rdata_i,
  output logic [2:0]      addr_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic [7:0]      wdata_o,
  output logic            xfer_end_o
);
  logic [7:0] data;
  logic       ok;
  initial begin
    addr_o = 3'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
    xfer_end_o = 1'b0;
  end
  // one strobe, answer taken after the taking edge, then end of transfer
  task automatic access(input logic [2:0] a, input logic w, input logic [7:0] d,
                        input int gap);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wr_o = w;
    rd_o = !w;
    wdata_o = d;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    rd_o = 1'b0;
    ok = ack_i;
    data = rdata_i;
    xfer_end_o = 1'b1;
    @(posedge clk_i);
    #1;
    xfer_end_o = 1'b0;
    // released lines must not keep their last value
    addr_o = ~a;
    wdata_o = ~d;
    repeat (gap) begin
      @(posedge clk_i);
      #1;
    end
  endtask
endmodule

// >>> verif/pxr_core_tb.sv
`timescale 1ns/100ps
`include "pxr_consts.svh"
module pxr_core_tb;
  localparam int DIV = `PXR_CLK_KHZ / `PXR_OSC_KHZ;
  logic clk_i, sys_rst_i, wr, rd, xend, ack, led, conv, int_n, int_oe;
  logic [2:0]  addr;
  logic [7:0]  wdata, rdata;
  logic [15:0] raw, amb, nlen;
  logic [1:0]  cur, full_scale_range;
  logic        led_seen, led_all;
  int          n_mismatch, checks, cyc, i;

  pxr_core dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .xfer_end_i(xend), .reg_rdata_o(rdata),
    .reg_ack_o(ack), .adc_raw_i(raw), .adc_ambient_i(amb), .led_drive_pin_o(led),
    .led_current_o(cur), .full_scale_range_o(full_scale_range), .converting_o(conv),
    .int_n_o(int_n), .int_n_oe_o(int_oe));
  pxr_host host (.clk_i(clk_i), .ack_i(ack), .rdata_i(rdata), .addr_o(addr), .wr_o(wr),
    .rd_o(rd), .wdata_o(wdata), .xfer_end_o(xend));

  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic summarize();
    if (n_mismatch == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrr(input logic [2:0] a, input logic [7:0] d);
    host.access(a, 1'b1, d, 0);
    chk(host.ok, 1'b1);
  endtask
  task automatic rdr(input logic [2:0] a, input logic [7:0] e);
    host.access(a, 1'b0, 8'h00, 2);
    chk({host.ok, host.data}, {1'b1, e});
  endtask
  task automatic wait_conv();
    int w;
    w = 0;
    nlen = 0;
    led_seen = 1'b0;
    led_all = 1'b1;
    while (conv !== 1'b1 && w < 40) begin
      @(posedge clk_i);
      #1;
      w++;
    end
    while (conv === 1'b1 && nlen < 3000) begin
      led_seen = led_seen | led;
      led_all = led_all & led;
      @(posedge clk_i);
      #1;
      nlen++;
    end
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  initial begin
    clk_i = 1'b0;
    sys_rst_i = 1'b1;
    raw = 16'h0000;
    amb = 16'h0000;
    n_mismatch = 0;
    checks = 0;
    cyc = 0;
    repeat (10) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    chk({int_n, int_oe, led}, 3'b000);
    rdr(3'h2, 8'h00);
    rdr(3'h3, 8'h00);
    rdr(3'h4, 8'h00);
    rdr(3'h5, 8'h00);
    rdr(3'h6, 8'hFF);
    rdr(3'h7, 8'hFF);
    wrr(3'h5, 8'hA5);
    rdr(3'h5, 8'hA5);
    wrr(3'h2, 8'h77);
    rdr(3'h2, 8'h00);
    for (i = 0; i < 4; i++) begin
      wrr(3'h1, {1'b1, i[0], i[1:0], 2'b11, ~i[1:0]});
      rdr(3'h1, {1'b1, i[0], i[1:0], 2'b11, ~i[1:0]});
      chk({cur, full_scale_range}, {i[1:0], ~i[1:0]});
    end
    // window 0000..0003 for the interrupt runs
    wrr(3'h5, 8'h00);
    wrr(3'h6, 8'h03);
    wrr(3'h7, 8'h00);
    rdr(3'h6, 8'h03);
    wrr(3'h1, 8'h8C);
    raw = 16'h12A5;
    wrr(3'h0, 8'h40);
    wait_conv();
    chk(nlen >= 15 * DIV && nlen <= 17 * DIV, 1'b1);
    chk(led_seen, 1'b0);
    chk(int_oe, 1'b1);
    rdr(3'h2, 8'h05);
    rdr(3'h3, 8'h00);
    chk(int_oe, 1'b1);
    rdr(3'h0, 8'h04);
    chk(int_oe, 1'b0);
    raw = 16'h0005;
    amb = 16'h0003;
    wrr(3'h0, 8'h60);
    wait_conv();
    chk({led_seen, led_all}, 2'b11);
    rdr(3'h2, 8'h02);
    chk(int_oe, 1'b0);
    wrr(3'h1, 8'hCC);
    // difference beyond the 4-bit signed span saturates
    raw = 16'h000F;
    amb = 16'h0001;
    wrr(3'h0, 8'h60);
    wait_conv();
    chk({led_seen, led_all}, 2'b10);
    rdr(3'h2, 8'h07);
    chk(int_oe, 1'b1);
    // continuous IR, persist of four, result refreshed each time
    raw = 16'h7F9F;
    wrr(3'h0, 8'hC1);
    for (i = 1; i <= 4; i++) begin
      wait_conv();
      chk(int_oe, i == 4);
      rdr(3'h2, {4'h0, raw[3:0]});
      raw = 16'h0008 + i[15:0];
    end
    wrr(3'h0, 8'h00);
    chk(int_oe, 1'b0);
    // reserved operation code is stored but starts nothing
    wrr(3'h0, 8'h20);
    chk(conv, 1'b0);
    summarize();
  end
endmodule
